// ==== pkg/seq_cfg_pkg.sv ====
// Constants, register layouts and helpers for the output sequencing register slice
package seq_cfg_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OUT_A_DELAY_ADDR = 8'h10;
  localparam logic [7:0] OUT_B_DELAY_ADDR = 8'h11;
  localparam logic [7:0] OUTPUT_CONTROL_ADDR = 8'h12;
  localparam logic [7:0] MISC_CONFIG_ADDR = 8'h13;
  localparam logic [7:0] CLOCK_SYNC_ADDR = 8'h14;
  localparam logic [7:0] SEQ_STATUS_ADDR = 8'h3F;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] DELAY_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MISC_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CLOCK_SYNC_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_CONTROL_WRITE_MASK = 8'h77;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // Field positions of the status register
  // ---------------------------------------------------------------
  localparam int STATUS_ON_OFF_BIT = 0;
  localparam int STATUS_SEQ_A_BIT = 1;
  localparam int STATUS_SEQ_B_BIT = 2;
  localparam int STATUS_EXT_PRESENT_BIT = 3;
  localparam int STATUS_USE_EXT_BIT = 4;
  localparam int STATUS_FREQ_INVALID_BIT = 5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES = (HALF_MS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CLK_ABSENT_CYCLES = 64;
  localparam logic [4:0] EXT_FREQ_MAX_CODE = 5'h17;

  // ---------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] off_delay;
    logic [3:0] on_delay;
  } delay_reg_t;

  typedef struct packed {
    logic rsvd7;
    logic output_b_drain_select;
    logic output_b_pin_gating;
    logic output_b_level;
    logic rsvd3;
    logic output_a_open_drain;
    logic output_a_pin_gating;
    logic output_a_level;
  } output_control_t;

  typedef struct packed {
    logic rsvd7;
    logic startup_range;
    logic shutdown_range;
    logic dual_pin_function;
    logic dual_pin_pulldown;
    logic on_off_pin_pulldown;
    logic thermal_warning_threshold;
    logic spread_spectrum_on;
  } misc_config_t;

  typedef struct packed {
    logic rsvd7;
    logic pll_enable;
    logic rsvd5;
    logic [4:0] external_frequency_code;
  } clock_sync_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Delay in half-millisecond ticks; long range doubles each step
  function automatic logic [4:0] delay_half_ms_steps(input logic [3:0] code, input logic long_range);
    delay_half_ms_steps = long_range ? {code, 1'b0} : {1'b0, code};
  endfunction

endpackage

// ==== verilog/seq_delay_channel.sv ====
// Delayed copy of the on/off level for one sequenced output
`timescale 1ns/1ps
`default_nettype none
module seq_delay_channel #(
  parameter int HALF_MS_CYCLES = seq_cfg_pkg::HALF_MS_CYCLES
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic pin_level_in,
  input wire logic [3:0] on_delay_in,
  input wire logic [3:0] off_delay_in,
  input wire logic on_range_in,
  input wire logic off_range_in,
  output logic seq_level_out,
  output logic busy_out
);
  import seq_cfg_pkg::*;

  localparam int PW = $clog2(HALF_MS_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(HALF_MS_CYCLES - 1);

  logic target_q;
  logic seq_q;
  logic [4:0] steps_q;
  logic [PW-1:0] pre_q;
  logic [4:0] load_steps;
  logic edge_seen;
  logic tick;

  // ---------------------------------------------------------------
  // Edge and delay selection
  // ---------------------------------------------------------------
  assign load_steps = pin_level_in ? delay_half_ms_steps(on_delay_in, on_range_in)
                                   : delay_half_ms_steps(off_delay_in, off_range_in);
  assign edge_seen = pin_level_in != target_q;
  assign tick = pre_q == PRE_LAST;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      target_q <= 1'b0;
    end else if (clk_en_in && edge_seen) begin
      target_q <= pin_level_in;
    end
  end

  // ---------------------------------------------------------------
  // Step counter
  // ---------------------------------------------------------------
  // Prescaler restarts on each edge so the first step is a full step
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      steps_q <= 5'h00;
      pre_q <= '0;
    end else if (clk_en_in) begin
      if (edge_seen) begin
        steps_q <= load_steps; // RL21
        pre_q <= '0;
      end else if (steps_q != 5'h00) begin
        if (tick) begin
          pre_q <= '0;
          steps_q <= steps_q - 5'h01;
        end else begin
          pre_q <= pre_q + PW'(1);
        end
      end
    end
  end

  // A reversal mid-delay simply restarts towards the new level
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seq_q <= 1'b0;
    end else if (clk_en_in) begin
      if (edge_seen && load_steps == 5'h00) begin
        seq_q <= pin_level_in;
      end else if (!edge_seen && steps_q == 5'h01 && tick) begin
        seq_q <= target_q;
      end
    end
  end

  assign seq_level_out = seq_q;
  assign busy_out = steps_q != 5'h00;

endmodule // seq_delay_channel
`default_nettype wire

// ==== verilog/ext_clock_monitor.sv ====
// Presence detector for the external clock on the dual-use pin
`timescale 1ns/1ps
`default_nettype none
module ext_clock_monitor #(
  parameter int ABSENT_CYCLES = seq_cfg_pkg::CLK_ABSENT_CYCLES
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic pin_in,
  input wire logic monitor_en_in,
  output logic present_out,
  output logic change_event_out
);
  import seq_cfg_pkg::*;

  localparam int CW = $clog2(ABSENT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(ABSENT_CYCLES);

  logic [2:0] sync_q;
  logic [CW-1:0] idle_q;
  logic present_q;
  logic event_q;
  logic pin_toggle;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  // Only toggles are seen; clocks above half of clock_in alias
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_q <= 3'h0;
    end else if (clk_en_in) begin
      sync_q <= {sync_q[1:0], pin_in};
    end
  end

  assign pin_toggle = sync_q[1] != sync_q[2];

  // ---------------------------------------------------------------
  // Presence and change event
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idle_q <= '0;
    end else if (clk_en_in) begin
      if (!monitor_en_in || pin_toggle) begin
        idle_q <= '0;
      end else if (idle_q != CNT_LAST) begin
        idle_q <= idle_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      present_q <= 1'b0;
      event_q <= 1'b0;
    end else if (clk_en_in) begin
      event_q <= 1'b0;
      if (!monitor_en_in) begin
        present_q <= 1'b0;
      end else if (pin_toggle && !present_q) begin
        present_q <= 1'b1;
        event_q <= 1'b1; // RL17
      end else if (!pin_toggle && present_q && idle_q == CNT_LAST) begin
        present_q <= 1'b0;
        event_q <= 1'b1; // RL17
      end
    end
  end

  assign present_out = present_q;
  assign change_event_out = event_q;

endmodule // ext_clock_monitor
`default_nettype wire

// ==== verilog/output_sequencing_config_regs.sv ====
// Output sequencing and configuration register slice
// Behaviour
// RL1 - output_b fall delayed by off-delay nibble
// RL2 - output_b rise delayed by on-delay nibble
// RL3 - Bit 6 picks output_b push-pull or open-drain
// RL4 - Bit 5 ANDs output_b level with pin
// RL5 - Bit 4 sets output_b level
// RL6 - Bit 2 picks output_a push-pull or open-drain
// RL7 - Bit 1 ANDs output_a level with pin
// RL8 - Bit 0 sets output_a level
// RL9 - Config bit 6 selects startup step size
// RL10 - Config bit 5 selects shutdown step size
// RL11 - Config bit 4 picks pin output or clock
// RL12 - Config bit 3 enables dual pin pull-down
// RL13 - Config bit 2 enables on/off pin pull-down
// RL14 - Config bit 1 picks thermal warning threshold
// RL15 - Config bit 0 enables spread spectrum
// RL16 - PLL bit 6 enables PLL, else RC oscillator
// RL17 - External clock change raises event while enabled
// RL18 - Software writes zero to PLL bit 5
// RL19 - Frequency code is code plus one MHz
// RL20 - output_a delays held at 0x10, same scaling
// RL21 - Delay is code times selected step
// RL22 - Control bits 7 and 3 read zero
`timescale 1ns/1ps
`default_nettype none
module output_sequencing_config_regs #(
  parameter int HALF_MS_CYCLES = seq_cfg_pkg::HALF_MS_CYCLES,
  parameter int CLK_ABSENT_CYCLES = seq_cfg_pkg::CLK_ABSENT_CYCLES
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire seq_cfg_pkg::reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic on_off_pin_in,
  input wire logic dual_use_clock_pin_in,
  output logic output_a_out,
  output logic output_a_oe_out,
  output logic output_b_out,
  output logic output_b_oe_out,
  output logic dual_pin_pulldown_out,
  output logic on_off_pin_pulldown_out,
  output logic thermal_warning_threshold_out,
  output logic spread_spectrum_on_out,
  output logic pll_enable_out,
  output logic internal_osc_forced_out,
  output logic use_external_clock_out,
  output logic [4:0] external_frequency_code_out,
  output logic ext_clock_present_out,
  output logic clock_event_out
);
  import seq_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  delay_reg_t out_a_delay_q;
  delay_reg_t out_b_delay_q;
  output_control_t out_ctrl_q;
  misc_config_t misc_cfg_q;
  clock_sync_t clk_sync_q;
  logic [2:0] on_off_sync_q;
  logic on_off_level_q;
  logic seq_a;
  logic seq_b;
  logic busy_a;
  logic busy_b;
  logic ext_present;
  logic ext_event;
  logic monitor_en;
  logic freq_valid;
  logic level_a;
  logic level_b;
  logic out_a_q;
  logic oe_a_q;
  logic out_b_q;
  logic oe_b_q;
  logic use_ext_q;
  logic [7:0] status;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // ---------------------------------------------------------------
  // On/off pin synchroniser
  // ---------------------------------------------------------------
  // Level only accepted once the last two stages agree
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      on_off_sync_q <= 3'h0;
    end else if (clk_en_in) begin
      on_off_sync_q <= {on_off_sync_q[1:0], on_off_pin_in};
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      on_off_level_q <= 1'b0;
    end else if (clk_en_in && on_off_sync_q[1] == on_off_sync_q[2]) begin
      on_off_level_q <= on_off_sync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_a_delay_q <= delay_reg_t'(DELAY_RESET);
    end else if (clk_en_in && reg_req_in.wr && reg_req_in.addr == OUT_A_DELAY_ADDR) begin
      out_a_delay_q <= delay_reg_t'(reg_req_in.wdata); // RL20
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_b_delay_q <= delay_reg_t'(DELAY_RESET);
    end else if (clk_en_in && reg_req_in.wr && reg_req_in.addr == OUT_B_DELAY_ADDR) begin
      out_b_delay_q <= delay_reg_t'(reg_req_in.wdata);
    end
  end

  // Reserved control bits are never stored
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_ctrl_q <= output_control_t'(OUTPUT_CONTROL_RESET);
    end else if (clk_en_in && reg_req_in.wr && reg_req_in.addr == OUTPUT_CONTROL_ADDR) begin
      out_ctrl_q <= output_control_t'(reg_req_in.wdata & OUTPUT_CONTROL_WRITE_MASK); // RL22
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      misc_cfg_q <= misc_config_t'(MISC_CONFIG_RESET);
    end else if (clk_en_in && reg_req_in.wr && reg_req_in.addr == MISC_CONFIG_ADDR) begin
      misc_cfg_q <= misc_config_t'(reg_req_in.wdata);
    end
  end

  // Bit 5 is stored as written; the host keeps it at zero
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      clk_sync_q <= clock_sync_t'(CLOCK_SYNC_RESET);
    end else if (clk_en_in && reg_req_in.wr && reg_req_in.addr == CLOCK_SYNC_ADDR) begin
      clk_sync_q <= clock_sync_t'(reg_req_in.wdata);
    end
  end

  // ---------------------------------------------------------------
  // Delay sequencing
  // ---------------------------------------------------------------
  seq_delay_channel #(
    .HALF_MS_CYCLES(HALF_MS_CYCLES)
  ) u_seq_a (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .pin_level_in(on_off_level_q),
    .on_delay_in(out_a_delay_q.on_delay), // RL20
    .off_delay_in(out_a_delay_q.off_delay), // RL20
    .on_range_in(misc_cfg_q.startup_range), // RL9
    .off_range_in(misc_cfg_q.shutdown_range), // RL10
    .seq_level_out(seq_a),
    .busy_out(busy_a)
  );

  seq_delay_channel #(
    .HALF_MS_CYCLES(HALF_MS_CYCLES)
  ) u_seq_b (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .pin_level_in(on_off_level_q),
    .on_delay_in(out_b_delay_q.on_delay), // RL2
    .off_delay_in(out_b_delay_q.off_delay), // RL1
    .on_range_in(misc_cfg_q.startup_range), // RL9
    .off_range_in(misc_cfg_q.shutdown_range), // RL10
    .seq_level_out(seq_b),
    .busy_out(busy_b)
  );

  // ---------------------------------------------------------------
  // External clock supervision
  // ---------------------------------------------------------------
  // Watching is pointless while the pin serves as an output
  assign monitor_en = clk_sync_q.pll_enable && misc_cfg_q.dual_pin_function; // RL17

  ext_clock_monitor #(
    .ABSENT_CYCLES(CLK_ABSENT_CYCLES)
  ) u_ext_clk (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .pin_in(dual_use_clock_pin_in),
    .monitor_en_in(monitor_en),
    .present_out(ext_present),
    .change_event_out(ext_event)
  );

  // Reserved frequency codes keep the PLL on the internal oscillator
  assign freq_valid = clk_sync_q.external_frequency_code <= EXT_FREQ_MAX_CODE; // RL19

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      use_ext_q <= 1'b0;
    end else if (clk_en_in) begin
      use_ext_q <= clk_sync_q.pll_enable && ext_present && freq_valid; // RL16
    end
  end

  // ---------------------------------------------------------------
  // Output drivers
  // ---------------------------------------------------------------
  // Pin gating follows the sequenced copy of the on/off level
  assign level_a = out_ctrl_q.output_a_level && (!out_ctrl_q.output_a_pin_gating || seq_a); // RL7 RL8
  assign level_b = out_ctrl_q.output_b_level && (!out_ctrl_q.output_b_pin_gating || seq_b); // RL4 RL5

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_a_q <= 1'b0;
      oe_a_q <= 1'b0;
    end else if (clk_en_in) begin
      if (out_ctrl_q.output_a_open_drain) begin
        out_a_q <= 1'b0; // RL6
        oe_a_q <= !level_a; // RL6
      end else begin
        out_a_q <= level_a;
        oe_a_q <= 1'b1;
      end
    end
  end

  // In clock function the pin is released whatever the control bits say
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_b_q <= 1'b0;
      oe_b_q <= 1'b0;
    end else if (clk_en_in) begin
      if (misc_cfg_q.dual_pin_function) begin
        out_b_q <= 1'b0; // RL11
        oe_b_q <= 1'b0; // RL11
      end else if (out_ctrl_q.output_b_drain_select) begin
        out_b_q <= 1'b0; // RL3
        oe_b_q <= !level_b; // RL3
      end else begin
        out_b_q <= level_b;
        oe_b_q <= 1'b1;
      end
    end
  end

  assign output_a_out = out_a_q;
  assign output_a_oe_out = oe_a_q;
  assign output_b_out = out_b_q;
  assign output_b_oe_out = oe_b_q;

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  assign dual_pin_pulldown_out = misc_cfg_q.dual_pin_pulldown; // RL12
  assign on_off_pin_pulldown_out = misc_cfg_q.on_off_pin_pulldown; // RL13
  assign thermal_warning_threshold_out = misc_cfg_q.thermal_warning_threshold; // RL14
  assign spread_spectrum_on_out = misc_cfg_q.spread_spectrum_on; // RL15
  assign pll_enable_out = clk_sync_q.pll_enable; // RL16
  assign internal_osc_forced_out = !clk_sync_q.pll_enable; // RL16
  assign use_external_clock_out = use_ext_q;
  assign external_frequency_code_out = clk_sync_q.external_frequency_code; // RL19
  assign ext_clock_present_out = ext_present;
  assign clock_event_out = ext_event;

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always_comb begin
    status = 8'h00;
    status[STATUS_ON_OFF_BIT] = on_off_level_q;
    status[STATUS_SEQ_A_BIT] = seq_a;
    status[STATUS_SEQ_B_BIT] = seq_b;
    status[STATUS_EXT_PRESENT_BIT] = ext_present;
    status[STATUS_USE_EXT_BIT] = use_ext_q;
    status[STATUS_FREQ_INVALID_BIT] = !freq_valid;
  end

  always_comb begin
    unique case (reg_req_in.addr)
      OUT_A_DELAY_ADDR: rdata_d = out_a_delay_q;
      OUT_B_DELAY_ADDR: rdata_d = out_b_delay_q;
      OUTPUT_CONTROL_ADDR: rdata_d = out_ctrl_q & OUTPUT_CONTROL_WRITE_MASK; // RL22
      MISC_CONFIG_ADDR: rdata_d = misc_cfg_q;
      CLOCK_SYNC_ADDR: rdata_d = clk_sync_q;
      SEQ_STATUS_ADDR: rdata_d = status;
      default: rdata_d = UNMAPPED_READ;
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
    end else if (clk_en_in && reg_req_in.rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule // output_sequencing_config_regs
`default_nettype wire

// ==== verification/output_sequencing_config_regs_chk.sv ====
// Port-level checker for the output sequencing slice
`timescale 1ns/1ps
`default_nettype none
module output_sequencing_config_regs_chk (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire seq_cfg_pkg::reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic output_a_out,
  input wire logic output_a_oe_out,
  input wire logic output_b_out,
  input wire logic output_b_oe_out,
  input wire logic dual_pin_pulldown_out,
  input wire logic on_off_pin_pulldown_out,
  input wire logic thermal_warning_threshold_out,
  input wire logic spread_spectrum_on_out,
  input wire logic pll_enable_out,
  input wire logic internal_osc_forced_out,
  input wire logic use_external_clock_out,
  input wire logic [4:0] external_frequency_code_out,
  input wire logic ext_clock_present_out,
  input wire logic clock_event_out
);
  import seq_cfg_pkg::*;
  // ----------------
  // Shadow registers
  // ----------------
  logic [7:0] ctrl_q, misc_q, pll_q;
  // Mirrors bus writes, so no internal probes are needed
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= OUTPUT_CONTROL_RESET;
      misc_q <= MISC_CONFIG_RESET;
      pll_q <= CLOCK_SYNC_RESET;
    end else if (clk_en_in && reg_req_in.wr) begin
      if (reg_req_in.addr == OUTPUT_CONTROL_ADDR) ctrl_q <= reg_req_in.wdata & 8'h77;
      if (reg_req_in.addr == MISC_CONFIG_ADDR) misc_q <= reg_req_in.wdata;
      if (reg_req_in.addr == CLOCK_SYNC_ADDR) pll_q <= reg_req_in.wdata;
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  AST_RD_CTRL: assert property (
    clk_en_in && reg_req_in.rd && reg_req_in.addr == OUTPUT_CONTROL_ADDR |=> reg_rdata_out == $past(ctrl_q))
    else $error("control readback wrong");
  AST_CFG_PINS: assert property (
    {dual_pin_pulldown_out, on_off_pin_pulldown_out, thermal_warning_threshold_out, spread_spectrum_on_out}
    == misc_q[3:0]) else $error("config pin levels wrong");
  AST_PLL: assert property (
    pll_enable_out == pll_q[6] && internal_osc_forced_out == !pll_q[6] && external_frequency_code_out == pll_q[4:0])
    else $error("clock sync fields wrong");
  AST_USE_EXT: assert property (
    use_external_clock_out |-> $past(pll_enable_out) && $past(external_frequency_code_out) <= 5'h17)
    else $error("external clock used wrongly");
  AST_EVT_CHG: assert property (
    clock_event_out |-> $changed(ext_clock_present_out) && $past(pll_enable_out))
    else $error("event without presence change");
  AST_EVT_PULSE: assert property (
    clock_event_out |=> !clock_event_out) else $error("event longer than a cycle");
  AST_A_PUSH: assert property (
    (ctrl_q[2:1] == 2'b00 && $stable(ctrl_q)) [*4] |-> output_a_oe_out && output_a_out == ctrl_q[0])
    else $error("output_a push-pull wrong");
  AST_A_OD: assert property (
    (ctrl_q[2:1] == 2'b10 && $stable(ctrl_q)) [*4] |-> !output_a_out && output_a_oe_out == !ctrl_q[0])
    else $error("output_a open-drain wrong");
  AST_B_CLOCK: assert property (
    (misc_q[4] && $stable(misc_q)) [*4] |-> !output_b_oe_out && !output_b_out)
    else $error("output_b driven in clock mode");
  cover property (clock_event_out);
  cover property (use_external_clock_out);
  cover property ($rose(output_b_out));
endmodule // output_sequencing_config_regs_chk
`default_nettype wire

// ==== verification/output_sequencing_config_regs_tb.sv ====
// Self-checking bench for the output sequencing slice
`timescale 1ns/1ps
`default_nettype none
module output_sequencing_config_regs_tb;
  import seq_cfg_pkg::*;
  localparam int H = 4;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, tog = 1'b0, rd_pend = 1'b0;
  logic on_off_pin_in = 1'b0, dual_use_clock_pin_in = 1'b0;
  reg_req_t reg_req_in = '0;
  logic [7:0] reg_rdata_out, v;
  logic [4:0] external_frequency_code_out;
  logic output_a_out, output_a_oe_out, output_b_out, output_b_oe_out, dual_pin_pulldown_out;
  logic on_off_pin_pulldown_out, thermal_warning_threshold_out, spread_spectrum_on_out, pll_enable_out;
  logic internal_osc_forced_out, use_external_clock_out, ext_clock_present_out, clock_event_out;
  logic [31:0] seed = 32'h00000051;
  logic [7:0] rd_q[$];
  logic [7:0] ad[4] = '{8'h10, 8'h11, 8'h13, 8'h14};
  logic [7:0] cv[5] = '{8'h11, 8'h44, 8'h55, 8'h33, 8'hFF};
  logic [3:0] ons[6] = '{4'h0, 4'h1, 4'hF, 4'hF, 4'h7, 4'h0};
  logic [3:0] offs[6] = '{4'h0, 4'hF, 4'h2, 4'hF, 4'h9, 4'h0};
  logic [1:0] rg[6] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h1, 2'h2};
  int fail_count = 0, comparisons = 0, events = 0, cycles = 0, ra, rb, fa, fb, r0, f0;

  output_sequencing_config_regs #(.HALF_MS_CYCLES(H), .CLK_ABSENT_CYCLES(8)) u_output_sequencing_config_regs (.*);

  // ----------------
  // Helpers
  // ----------------
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Delay in edges beyond the zero-code baseline
  function automatic logic [15:0] dl(input logic [3:0] c, input logic r);
    int s;
    s = (r ? 2 * c : c) * H;
    return 16'(s);
  endfunction
  function automatic logic [1:0] drv(input logic [2:0] c);
    logic e;
    e = c[0] & ~c[1];
    return c[2] ? {1'b0, ~e} : {e, 1'b1};
  endfunction
  task automatic chk(input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, d, input logic w);
    @(posedge clock_in);
    reg_req_in <= {a, d, w, !w};
    @(posedge clock_in);
    reg_req_in <= '0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    rd_q.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask
  // Edges until each output reaches the target level
  task automatic meas(input logic t, output int la, lb);
    la = -1;
    lb = -1;
    on_off_pin_in <= t;
    for (int n = 0; n < 300 && (la < 0 || lb < 0); n++) begin
      @(posedge clock_in);
      if (la < 0 && output_a_out === t) la = n;
      if (lb < 0 && output_b_out === t) lb = n;
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------
  // Watchers
  // ----------------
  always @(posedge clock_in) begin
    if (rd_pend) chk(reg_rdata_out, rd_q.pop_front());
    rd_pend <= reg_req_in.rd;
    if (clock_event_out === 1'b1) events++;
    if (tog) dual_use_clock_pin_in <= ~dual_use_clock_pin_in;
  end
  // Budget is about twenty times the expected run
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------
  // Scenarios
  // ----------------
  initial begin
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    for (int k = 0; k < 6; k++) rd(8'h10 + k[7:0], 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = xs();
      if (k == 3) v = v & 8'h4F;
      bus(ad[k], v, 1'b1);
      rd(ad[k], v);
    end
    bus(8'h20, v, 1'b1);
    rd(8'h20, 8'h00);
    bus(OUTPUT_CONTROL_ADDR, 8'h33, 1'b1);
    for (int i = 0; i < 6; i++) begin
      v = xs();
      if (i == 5) begin
        ons[i] = v[3:0];
        offs[i] = v[7:4];
      end
      bus(8'h10, {offs[i], ons[i]}, 1'b1);
      bus(8'h11, {offs[i], ons[i]}, 1'b1);
      bus(MISC_CONFIG_ADDR, {1'b0, rg[i], 5'h00}, 1'b1);
      meas(1'b1, ra, rb);
      meas(1'b0, fa, fb);
      if (i == 0) begin
        r0 = ra;
        f0 = fa;
      end
      chk(16'(ra - r0), dl(ons[i], rg[i][1]));
      chk(16'(rb - r0), dl(ons[i], rg[i][1]));
      chk(16'(fa - f0), dl(offs[i], rg[i][0]));
      chk(16'(fb - f0), dl(offs[i], rg[i][0]));
    end
    for (int k = 0; k < 5; k++) begin
      bus(OUTPUT_CONTROL_ADDR, cv[k], 1'b1);
      repeat (6) @(posedge clock_in);
      chk({output_a_out, output_a_oe_out}, drv(cv[k][2:0]));
      chk({output_b_out, output_b_oe_out}, drv(cv[k][6:4]));
      rd(OUTPUT_CONTROL_ADDR, cv[k] & 8'h77);
    end
    bus(MISC_CONFIG_ADDR, 8'h18, 1'b1);
    repeat (6) @(posedge clock_in);
    chk({output_b_out, output_b_oe_out}, 2'b00);
    bus(CLOCK_SYNC_ADDR, 8'h45, 1'b1);
    for (int k = 0; k < 3; k++) begin
      tog <= (k != 1);
      repeat (40) @(posedge clock_in);
      chk({ext_clock_present_out, use_external_clock_out}, {2{k != 1}});
      rd(SEQ_STATUS_ADDR, {3'h0, {2{k != 1}}, 3'h0});
    end
    bus(CLOCK_SYNC_ADDR, 8'h05, 1'b1);
    repeat (10) @(posedge clock_in);
    tog <= 1'b0;
    chk({ext_clock_present_out, use_external_clock_out, internal_osc_forced_out}, 3'b001);
    chk(16'(events), 16'h0003);
    repeat (4) @(posedge clock_in);
    tally_and_finish();
  end
endmodule // output_sequencing_config_regs_tb

bind output_sequencing_config_regs output_sequencing_config_regs_chk u_output_sequencing_config_regs_chk (.*);
`default_nettype wire
